// ===== bridge_ctrl_pm_pkg.sv
// constants for the bridge control upper half and power management capability header
// assumes one switch port per instance, configuration offsets given as byte addresses
package bridge_ctrl_pm_pkg;

    // register offsets (byte addresses, dword aligned)
    localparam logic [7:0]  BRIDGE_CTRL_OFF   = 8'h3C;
    localparam logic [7:0]  PM_CAP_OFF        = 8'h40;

    // bridge control bit positions within the 0x3C dword
    localparam int          VGA_EN_BIT        = 19;
    localparam int          VGA_16BIT_BIT     = 20;
    localparam int          MASTER_ABORT_BIT  = 21;
    localparam int          SEC_BUS_RESET_BIT = 22;
    localparam int          LEGACY_LO_BIT     = 23;
    localparam int          LEGACY_HI_BIT     = 27;
    localparam int          RSVD_LO_BIT       = 28;
    localparam int          BRIDGE_BYTE_LANE  = 2;

    // bridge control reset values
    localparam logic        VGA_EN_RST        = 1'b0;
    localparam logic        VGA_16BIT_RST     = 1'b0;
    localparam logic        SEC_BUS_RESET_RST = 1'b0;

    // power management capability field positions
    localparam int          PM_ID_LSB         = 0;
    localparam int          PM_NEXT_LSB       = 8;
    localparam int          PM_REV_LSB        = 16;
    localparam int          PM_CLOCK_BIT      = 19;
    localparam int          PM_RSVD_BIT       = 20;
    localparam int          PM_OVR_LSB        = 21;
    localparam int          PM_OVR_W          = 11;

    // power management constants and overridable defaults
    localparam logic [7:0]  PM_CAP_ID         = 8'h01;
    localparam logic [7:0]  PM_NEXT_PTR       = 8'h4C;
    localparam logic [2:0]  PM_REVISION       = 3'h3;
    localparam logic        PM_DSI_RST        = 1'b0;
    localparam logic [2:0]  PM_AUX_RST        = 3'h7;
    localparam logic        PM_D1_RST         = 1'b1;
    localparam logic        PM_D2_RST         = 1'b1;
    localparam logic [4:0]  PM_PME_RST        = 5'h1F;

    // vga decode windows
    localparam logic [31:0] VGA_MEM_LO        = 32'h000A_0000;
    localparam logic [31:0] VGA_MEM_HI        = 32'h000B_FFFF;
    localparam logic [9:0]  VGA_IO_A_LO       = 10'h3B0;
    localparam logic [9:0]  VGA_IO_A_HI       = 10'h3BB;
    localparam logic [9:0]  VGA_IO_B_LO       = 10'h3C0;
    localparam logic [9:0]  VGA_IO_B_HI       = 10'h3DF;

    // downstream port count of the switch
    localparam int          DN_PORTS          = 3;

    // msb first, so the packed struct drops straight onto pm bits 31:21
    typedef struct packed {
        logic [4:0]  pme;
        logic        d2;
        logic        d1;
        logic [2:0]  aux;
        logic        dsi;
    } pm_ovr_t;

    localparam pm_ovr_t     PM_OVR_RST        = '{pme: PM_PME_RST, d2: PM_D2_RST, d1: PM_D1_RST,
                                                  aux: PM_AUX_RST, dsi: PM_DSI_RST};

endpackage : bridge_ctrl_pm_pkg

// ===== vga_window_decode.sv
// vga address window decoder with registered forward / drop verdicts
// assumes requests are single-cycle strobes synchronous to clock
`timescale 1ns/10ps
module vga_window_decode
    import bridge_ctrl_pm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        vga_en,
    input  wire logic        vga_16bit,
    input  wire logic        req_valid,
    input  wire logic        req_is_mem,
    input  wire logic        req_is_io,
    input  wire logic [31:0] req_addr,
    output logic             fwd_ff,
    output logic             drop_ff
);

    typedef struct packed {
        logic fwd;
        logic drop;
    } dec_state_t;

    dec_state_t st_ff;
    dec_state_t nxt_st;
    logic       mem_hit;
    logic       io_hit;
    logic       in_win;

    always_comb begin
        mem_hit = req_is_mem && (req_addr >= VGA_MEM_LO) && (req_addr <= VGA_MEM_HI);
        // 16-bit decode also demands address bits 15:10 clear; 10-bit lets aliases through
        io_hit  = req_is_io && (req_addr[31:16] == 16'h0000)
                  && (!vga_16bit || req_addr[15:10] == 6'h00)
                  && (((req_addr[9:0] >= VGA_IO_A_LO) && (req_addr[9:0] <= VGA_IO_A_HI))
                      || ((req_addr[9:0] >= VGA_IO_B_LO) && (req_addr[9:0] <= VGA_IO_B_HI)));
        in_win  = req_valid && (mem_hit || io_hit);
        nxt_st.fwd  = in_win && vga_en;
        nxt_st.drop = in_win && !vga_en;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fwd_ff  = st_ff.fwd;
    assign drop_ff = st_ff.drop;

endmodule : vga_window_decode

// ===== bridge_ctrl_pm_cap_regs.sv
// bridge control upper half and power management capability header of one switch port
// assumes a single-cycle config access strobe, straps stable around reset release,
// and an smbus/eeprom loader that presents the overridable pm fields with a load strobe
`timescale 1ns/10ps
module bridge_ctrl_pm_cap_regs
    import bridge_ctrl_pm_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                resetn,
    input  wire logic                strap_upstream,
    input  wire logic [1:0]          strap_dn_index,
    input  wire logic                cfg_wr_en,
    input  wire logic                cfg_rd_en,
    input  wire logic [7:0]          cfg_addr,
    input  wire logic [3:0]          cfg_be,
    input  wire logic [31:0]         cfg_wdata,
    input  wire logic                ovr_load,
    input  wire logic [PM_OVR_W-1:0] ovr_data,
    input  wire logic                req_valid,
    input  wire logic                req_is_mem,
    input  wire logic                req_is_io,
    input  wire logic [31:0]         req_addr,
    output logic [31:0]              cfg_rdata_ff,
    output logic                     cfg_ack_ff,
    output logic                     hot_reset_ff,
    output logic [DN_PORTS-1:0]      dn_port_rst_n_ff,
    output logic                     vga_fwd_ff,
    output logic                     vga_drop_ff
);

    typedef struct packed {
        logic                strap_taken;
        logic                is_upstream;
        logic [1:0]          dn_index;
        logic                vga_en;
        logic                vga_16bit;
        logic                sec_bus_reset;
        pm_ovr_t             pm_ovr;
        logic [31:0]         rdata;
        logic                ack;
        logic                hot_reset;
        logic [DN_PORTS-1:0] rst_n;
    } regs_state_t;

    regs_state_t st_ff;
    regs_state_t nxt_st;

    function automatic logic [31:0] bridge_word(input logic vga_en,
                                                input logic vga_16bit,
                                                input logic sbr);
        logic [31:0] w;
        w                    = 32'h0000_0000;
        w[VGA_EN_BIT]        = vga_en;
        w[VGA_16BIT_BIT]     = vga_16bit;
        w[SEC_BUS_RESET_BIT] = sbr;
        return w;
    endfunction : bridge_word

    function automatic logic [31:0] pm_word(input pm_ovr_t ovr);
        logic [31:0] w;
        w                                      = 32'h0000_0000;
        w[PM_ID_LSB +: 8]                      = PM_CAP_ID;
        w[PM_NEXT_LSB +: 8]                    = PM_NEXT_PTR;
        w[PM_REV_LSB +: 3]                     = PM_REVISION;
        w[PM_CLOCK_BIT]                        = 1'b0;
        w[PM_RSVD_BIT]                         = 1'b0;
        w[PM_OVR_LSB +: PM_OVR_W]              = ovr;
        return w;
    endfunction : pm_word

    logic        bridge_sel;
    logic        pm_sel;
    logic        bridge_wr;
    logic [31:0] cur_bridge;

    always_comb begin
        nxt_st     = st_ff;
        bridge_sel = (cfg_addr[7:2] == BRIDGE_CTRL_OFF[7:2]);
        pm_sel     = (cfg_addr[7:2] == PM_CAP_OFF[7:2]);
        bridge_wr  = cfg_wr_en && bridge_sel && cfg_be[BRIDGE_BYTE_LANE];
        cur_bridge = bridge_word(st_ff.vga_en, st_ff.vga_16bit, st_ff.sec_bus_reset);

        // straps are caught by the first clock after reset release, never by the reset itself
        if (!st_ff.strap_taken) begin
            nxt_st.strap_taken = 1'b1;
            nxt_st.is_upstream = strap_upstream;
            nxt_st.dn_index    = strap_dn_index;
        end

        // only byte lane 2 carries writable bits; legacy and reserved bits are not stored at all
        if (bridge_wr) begin
            nxt_st.vga_en        = cfg_wdata[VGA_EN_BIT];
            nxt_st.vga_16bit     = cfg_wdata[VGA_16BIT_BIT];
            nxt_st.sec_bus_reset = cfg_wdata[SEC_BUS_RESET_BIT];
        end

        // pm header is read-only to config software; only the loader may replace defaults
        if (ovr_load) begin
            nxt_st.pm_ovr = pm_ovr_t'(ovr_data);
        end

        nxt_st.ack = cfg_wr_en || cfg_rd_en;
        if (cfg_rd_en && bridge_sel) begin
            nxt_st.rdata = cur_bridge;
        end else if (cfg_rd_en && pm_sel) begin
            nxt_st.rdata = pm_word(st_ff.pm_ovr);
        end else begin
            nxt_st.rdata = 32'h0000_0000;
        end

        nxt_st.hot_reset = st_ff.sec_bus_reset;

        // reset outputs follow the stored bit, so they stay asserted until software clears it
        nxt_st.rst_n = {DN_PORTS{1'b1}};
        if (st_ff.sec_bus_reset && st_ff.strap_taken) begin
            if (st_ff.is_upstream) begin
                nxt_st.rst_n = {DN_PORTS{1'b0}};
            end else if (32'(st_ff.dn_index) < DN_PORTS) begin
                nxt_st.rst_n[st_ff.dn_index] = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_ff.strap_taken   <= 1'b0;
            st_ff.is_upstream   <= 1'b0;
            st_ff.dn_index      <= 2'h0;
            st_ff.vga_en        <= VGA_EN_RST;
            st_ff.vga_16bit     <= VGA_16BIT_RST;
            st_ff.sec_bus_reset <= SEC_BUS_RESET_RST;
            st_ff.pm_ovr        <= PM_OVR_RST;
            st_ff.rdata         <= 32'h0000_0000;
            st_ff.ack           <= 1'b0;
            st_ff.hot_reset     <= 1'b0;
            st_ff.rst_n         <= {DN_PORTS{1'b1}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    vga_window_decode vga_window_decode_i (
        .clock      (clock),
        .resetn     (resetn),
        .vga_en     (st_ff.vga_en),
        .vga_16bit  (st_ff.vga_16bit),
        .req_valid  (req_valid),
        .req_is_mem (req_is_mem),
        .req_is_io  (req_is_io),
        .req_addr   (req_addr),
        .fwd_ff     (vga_fwd_ff),
        .drop_ff    (vga_drop_ff)
    );

    assign cfg_rdata_ff     = st_ff.rdata;
    assign cfg_ack_ff       = st_ff.ack;
    assign hot_reset_ff     = st_ff.hot_reset;
    assign dn_port_rst_n_ff = st_ff.rst_n;

endmodule : bridge_ctrl_pm_cap_regs

// ===== bridge_ctrl_pm_cap_regs_properties.sv
// port assertions for the bridge control and pm header block
// assumes one clock domain and straps held steady while out of reset
`timescale 1ns/10ps
module bridge_ctrl_pm_cap_regs_properties
    import bridge_ctrl_pm_pkg::*;
(
    input wire logic                clock,
    input wire logic                resetn,
    input wire logic                strap_upstream,
    input wire logic [1:0]          strap_dn_index,
    input wire logic                cfg_wr_en,
    input wire logic                cfg_rd_en,
    input wire logic [7:0]          cfg_addr,
    input wire logic [3:0]          cfg_be,
    input wire logic [31:0]         cfg_wdata,
    input wire logic                req_valid,
    input wire logic                req_is_mem,
    input wire logic                req_is_io,
    input wire logic [31:0]         req_addr,
    input wire logic [31:0]         cfg_rdata_ff,
    input wire logic                cfg_ack_ff,
    input wire logic                hot_reset_ff,
    input wire logic [DN_PORTS-1:0] dn_port_rst_n_ff,
    input wire logic                vga_fwd_ff,
    input wire logic                vga_drop_ff
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire bc_rd = cfg_rd_en && cfg_addr[7:2] == 6'h0F;
    wire pm_rd = cfg_rd_en && cfg_addr[7:2] == 6'h10;
    wire bc_wr = cfg_wr_en && cfg_addr[7:2] == 6'h0F && cfg_be[2];
    legacy_zero_a: assert property (bc_rd |=> cfg_rdata_ff[31:23] == 9'h0 && !cfg_rdata_ff[21])
        else $error("legacy or reserved bridge bit reads one");
    pm_fixed_a: assert property (pm_rd |=> cfg_rdata_ff[20:0] == 21'h034C01)
        else $error("fixed pm header fields wrong");
    hot_set_a: assert property (bc_wr && cfg_wdata[22] |-> ##2 hot_reset_ff)
        else $error("hot reset not raised");
    hot_clr_a: assert property (bc_wr && !cfg_wdata[22] |-> ##2 !hot_reset_ff)
        else $error("hot reset not cleared");
    up_all_a: assert property (strap_upstream && hot_reset_ff |-> dn_port_rst_n_ff == '0)
        else $error("upstream reset missed a port");
    dn_own_a: assert property (!strap_upstream && hot_reset_ff && strap_dn_index != 2'h3
        |-> !dn_port_rst_n_ff[strap_dn_index])
        else $error("downstream reset output not asserted");
    rst_idle_a: assert property (!hot_reset_ff |-> &dn_port_rst_n_ff)
        else $error("port reset without hot reset");
    vga_mem_a: assert property (req_valid && req_is_mem && req_addr inside {[VGA_MEM_LO:VGA_MEM_HI]}
        |=> vga_fwd_ff ^ vga_drop_ff)
        else $error("vga memory hit not classified");
    io_high_a: assert property (req_valid && req_is_io && req_addr[31:16] != 16'h0
        |=> !vga_fwd_ff && !vga_drop_ff)
        else $error("io above 64KB taken as vga");
    fwd_cause_a: assert property (vga_fwd_ff |-> $past(req_valid))
        else $error("forward without request");
    ack_follow_a: assert property (cfg_ack_ff == $past(cfg_wr_en || cfg_rd_en))
        else $error("config acknowledge not a one-cycle answer");
    rdata_idle_a: assert property (!cfg_rd_en |=> cfg_rdata_ff == 32'h0)
        else $error("read data stands without a read");
endmodule : bridge_ctrl_pm_cap_regs_properties

bind bridge_ctrl_pm_cap_regs bridge_ctrl_pm_cap_regs_properties bridge_ctrl_pm_cap_regs_properties_i (
    .clock, .resetn, .strap_upstream, .strap_dn_index, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_be,
    .cfg_wdata, .req_valid, .req_is_mem, .req_is_io, .req_addr, .cfg_rdata_ff, .cfg_ack_ff, .hot_reset_ff,
    .dn_port_rst_n_ff, .vga_fwd_ff, .vga_drop_ff);

// ===== bridge_ctrl_pm_cap_regs_tb_top.sv
// self-checking bench for the bridge control and pm header block
// assumes package and design compiled first; all waits are fixed by the access contract
`timescale 1ns/10ps
module bridge_ctrl_pm_cap_regs_tb_top;
    import bridge_ctrl_pm_pkg::*;
    logic                clock = 0, resetn = 0, strap_upstream = 0, cfg_wr_en = 0, cfg_rd_en = 0;
    logic                ovr_load = 0, req_valid = 0, req_is_mem = 0, req_is_io = 0;
    logic                cfg_ack_ff, hot_reset_ff, vga_fwd_ff, vga_drop_ff;
    logic [1:0]          strap_dn_index = 2'h1;
    logic [7:0]          cfg_addr = 8'h00;
    logic [3:0]          cfg_be = 4'h0;
    logic [31:0]         cfg_wdata = 32'h0, req_addr = 32'h0, cfg_rdata_ff;
    logic [PM_OVR_W-1:0] ovr_data = '0;
    logic [DN_PORTS-1:0] dn_port_rst_n_ff;
    int                  err_total = 0, num_checks = 0;
    always #2 clock = ~clock;
    bridge_ctrl_pm_cap_regs bridge_ctrl_pm_cap_regs_i (.clock, .resetn, .strap_upstream, .strap_dn_index,
        .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_be, .cfg_wdata, .ovr_load, .ovr_data, .req_valid,
        .req_is_mem, .req_is_io, .req_addr, .cfg_rdata_ff, .cfg_ack_ff, .hot_reset_ff,
        .dn_port_rst_n_ff, .vga_fwd_ff, .vga_drop_ff);
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic do_reset(logic up);
        if (resetn) @(posedge clock);
        resetn <= 1'b0;
        strap_upstream <= up;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
    endtask : do_reset
    task automatic acc(logic w, logic [7:0] a, logic [3:0] be, logic [31:0] d);
        @(posedge clock);
        cfg_wr_en <= w;
        cfg_rd_en <= !w;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge clock);
        cfg_wr_en <= 1'b0;
        cfg_rd_en <= 1'b0;
        #1;
        chk("ack", 32'h1, {31'h0, cfg_ack_ff});
    endtask : acc
    task automatic rd(logic [7:0] a, logic [31:0] e);
        acc(1'b0, a, 4'h0, 32'h0);
        chk("rdata", e, cfg_rdata_ff);
    endtask : rd
    // lane 2 only, so bits 19 and 20 go back to zero alongside
    task automatic sbr(logic v, logic [2:0] dn);
        acc(1'b1, BRIDGE_CTRL_OFF, 4'h4, {9'h0, v, 22'h0});
        @(posedge clock);
        #1;
        chk("hot", {31'h0, v}, {31'h0, hot_reset_ff});
        chk("dn_rst", {29'h0, dn}, {29'h0, dn_port_rst_n_ff});
    endtask : sbr
    task automatic req(logic m, logic [31:0] a, logic [1:0] e);
        @(posedge clock);
        req_valid <= 1'b1;
        req_is_mem <= m;
        req_is_io <= !m;
        req_addr <= a;
        @(posedge clock);
        req_valid <= 1'b0;
        #1;
        chk("vga", {30'h0, e}, {30'h0, vga_fwd_ff, vga_drop_ff});
    endtask : req
    task automatic s_bridge;
        rd(BRIDGE_CTRL_OFF, 32'h0);
        sbr(1'b1, 3'b101);
        acc(1'b1, BRIDGE_CTRL_OFF, 4'hF, 32'hFFFF_FFFF);
        rd(BRIDGE_CTRL_OFF, 32'h0058_0000);
        acc(1'b1, BRIDGE_CTRL_OFF, 4'hB, 32'h0);
        rd(BRIDGE_CTRL_OFF, 32'h0058_0000);
        sbr(1'b0, 3'b111);
    endtask : s_bridge
    task automatic s_pm;
        rd(PM_CAP_OFF, 32'hFFC3_4C01);
        acc(1'b1, PM_CAP_OFF, 4'hF, 32'h0);
        rd(PM_CAP_OFF, 32'hFFC3_4C01);
        @(posedge clock);
        ovr_load <= 1'b1;
        ovr_data <= 11'h555;
        @(posedge clock);
        ovr_load <= 1'b0;
        rd(PM_CAP_OFF, {11'h555, 5'h03, 8'h4C, 8'h01});
    endtask : s_pm
    task automatic s_vga;
        req(1'b1, 32'h000A_0000, 2'b01);
        req(1'b0, 32'h0000_03C4, 2'b01);
        acc(1'b1, BRIDGE_CTRL_OFF, 4'h4, 32'h0008_0000);
        req(1'b1, 32'h000A_0000, 2'b10);
        req(1'b1, 32'h000B_FFFF, 2'b10);
        req(1'b1, 32'h0009_FFFF, 2'b00);
        req(1'b1, 32'h000C_0000, 2'b00);
        req(1'b0, 32'h0000_03B0, 2'b10);
        req(1'b0, 32'h0000_03BB, 2'b10);
        req(1'b0, 32'h0000_03BC, 2'b00);
        req(1'b0, 32'h0000_03DF, 2'b10);
        req(1'b0, 32'h0000_03E0, 2'b00);
        req(1'b0, 32'h0001_03C0, 2'b00);
        req(1'b0, 32'h0000_07C0, 2'b10);
        acc(1'b1, BRIDGE_CTRL_OFF, 4'h4, 32'h0018_0000);
        req(1'b0, 32'h0000_07C0, 2'b00);
        req(1'b0, 32'h0000_03C0, 2'b10);
    endtask : s_vga
    // mid-run reset must drop the vga bits and the loaded pm values
    task automatic s_upstream;
        do_reset(1'b1);
        rd(BRIDGE_CTRL_OFF, 32'h0);
        rd(PM_CAP_OFF, 32'hFFC3_4C01);
        sbr(1'b1, 3'b000);
        sbr(1'b0, 3'b111);
    endtask : s_upstream
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    initial begin
        do_reset(1'b0);
        s_bridge();
        s_pm();
        s_vga();
        s_upstream();
        print_verdict();
    end
endmodule : bridge_ctrl_pm_cap_regs_tb_top
